// >>> bench/srcs_cpu_model.sv
/*
  cpu partner: takes a latched interrupt after a chosen delay.
  assumes irq_pending from the sequencer, all on clk.
*/
`timescale 1ns/1ps
module srcs_cpu_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic irq_pending,
  input wire logic svc_en,
  input wire logic [3:0] svc_delay,
  output logic irq_serviced
);
  logic [3:0] wait_cnt;
  // a slow answer leaves the latch standing, which the bench relies on
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_cnt <= 4'h0;
      irq_serviced <= 1'h0;
    end else begin
      irq_serviced <= 1'h0;
      if (!irq_pending || !svc_en || irq_serviced) begin
        wait_cnt <= 4'h0;
      end else if (wait_cnt == svc_delay) begin
        irq_serviced <= 1'h1;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule

// >>> bench/srcs_seq_asserts.sv
/*
  checker of the sequencer ports.
  assumes it is bound onto srcs_sequencer from the bench top.
*/
`timescale 1ns/1ps
`include "srcs_consts.svh"
module srcs_seq_asserts (
  input wire logic clk,
  input wire logic resetn,
  input wire logic bus_clk_en,
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic cpu_reset,
  input wire logic internal_reset,
  input wire logic illegal_op,
  input wire logic opcode_fetch,
  input wire logic unmapped_access,
  input wire logic wdog_reset_in,
  input wire logic monitor_mode,
  input wire logic test_high_voltage,
  input wire logic force_monitor,
  input wire logic [15:0] reset_vector,
  input wire logic i_mask,
  input wire logic irq_serviced,
  input wire logic irq_pending,
  input wire logic [2:0] irq_vector
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  div_four_a: assert property (bus_clk_en |=> !bus_clk_en [*3])
    else $error("bus clock enable closer than four cycles");
  held_clocks_a: assert property (cpu_reset |->
    !bus_clk_en && !cpu_clk_en) else $error("clock enable while cpu in reset");
  wait_gate_a: assert property (periph_clk_en == bus_clk_en &&
    (!cpu_clk_en || bus_clk_en)) else $error("clock enables disagree");
  vector_sel_a: assert property ($stable(monitor_mode) &&
    $stable(force_monitor) |-> reset_vector == ((monitor_mode ||
    force_monitor) ? `SRCS_VEC_MON : `SRCS_VEC_USER))
    else $error("wrong reset vector");
  bad_opcode_a: assert property (illegal_op && !cpu_reset |=>
    ##[0:3] internal_reset) else $error("illegal opcode ignored");
  bad_fetch_a: assert property (opcode_fetch && unmapped_access &&
    !cpu_reset |=> ##[0:3] internal_reset) else $error("bad fetch ignored");
  data_access_a: assert property (unmapped_access && !opcode_fetch &&
    !illegal_op && !cpu_reset |=> !internal_reset)
    else $error("data access caused reset");
  wdog_reset_a: assert property ($rose(wdog_reset_in) &&
    !cpu_reset && !(monitor_mode && test_high_voltage) |->
    ##[1:4] internal_reset) else $error("watchdog reset ignored");
  irq_hold_a: assert property (irq_pending && i_mask && !irq_serviced &&
    !internal_reset |=> irq_pending && $stable(irq_vector))
    else $error("latched interrupt lost");
endmodule

// >>> bench/srcs_sequencer_tb.sv
/*
  bench top: sequencer, cpu partner, bound checker, reset source tests.
  assumes srcs_consts.svh on the include path.
*/
`timescale 1ns/1ps
`include "srcs_consts.svh"
module srcs_sequencer_tb;
  logic clk = 1'h0;
  logic resetn, hsel, hwrite, wdog_reset_in, lv_trip, illegal_op, stop_exec;
  logic wait_exec, opcode_fetch, unmapped_access, vector_fetch, cpu_write;
  logic monitor_mode, test_high_voltage, wake_irq, i_mask, svc_en;
  logic hreadyout, hresp, internal_reset, cpu_reset, clockgen_output;
  logic bus_clk_en, cpu_clk_en, periph_clk_en, force_monitor;
  logic irq_pending, irq_serviced;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, irq_vector;
  logic [7:0] vector_data, irq_req, r;
  logic [15:0] cpu_addr, reset_vector;
  logic [3:0] svc_delay;
  logic [5:0] exp_cause [6] = '{6'h04, 6'h08, 6'h02, 6'h20, 6'h10, 6'h04};
  int mismatches = 0;
  int n_checks = 0;
  int n, b, c;
  always #12.5 clk = ~clk;
  srcs_sequencer srcs_sequencer_i (.clk, .resetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .wdog_reset_in, .lv_trip, .illegal_op, .stop_exec, .wait_exec,
    .opcode_fetch, .unmapped_access, .vector_fetch, .vector_data, .cpu_write,
    .cpu_addr, .monitor_mode, .test_high_voltage, .wake_irq, .irq_req, .i_mask,
    .irq_serviced, .internal_reset, .cpu_reset, .clockgen_output, .bus_clk_en,
    .cpu_clk_en, .periph_clk_en, .reset_vector, .force_monitor, .irq_pending,
    .irq_vector);
  srcs_cpu_model srcs_cpu_model_i (.clk, .resetn, .irq_pending, .svc_en,
    .svc_delay, .irq_serviced);
  task automatic chk(input logic [31:0] e, g, input string w);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // hsel and hsize stay fixed: only single word transfers are issued
  task automatic ahb(input logic w, input logic [31:0] a, d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clk);
    while (hreadyout !== 1'h1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'h1) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic cnt(input int cyc);
    b = 0;
    c = 0;
    repeat (cyc) begin
      @(posedge clk);
      b += int'(bus_clk_en === 1'h1);
      c += int'(cpu_clk_en === 1'h1);
    end
  endtask
  task automatic run_wait();
    n = 0;
    while (cpu_reset !== 1'h0) begin
      @(posedge clk);
      n++;
    end
  endtask
  function automatic logic [2:0] lowest(input logic [7:0] v);
    lowest = 3'h0;
    for (int i = 7; i >= 0; i--) if (v[i]) lowest = 3'(i);
  endfunction
  initial begin
    #(60000 * 25);
    mismatches++;
    final_report();
  end
  initial begin
    {resetn, hwrite, wdog_reset_in, lv_trip, illegal_op, stop_exec} = '0;
    {wait_exec, opcode_fetch, unmapped_access, vector_fetch, cpu_write} = '0;
    {monitor_mode, test_high_voltage, wake_irq, i_mask, svc_en} = '0;
    {haddr, hwdata, htrans, vector_data, irq_req, cpu_addr, svc_delay} = '0;
    hsel = 1'h1;
    hsize = 3'h2;
    void'($urandom(61));
    repeat (16) @(posedge clk);
    chk(1, internal_reset, "por reset");
    chk(1, clockgen_output, "clock output");
    resetn <= 1'h1;
    run_wait();
    chk(1, n >= 4160 && n <= 4162, "release time");
    ahb(0, `SRCS_OFF_CAUSE, 0);
    chk(32'h1, rd, "por cause");
    chk(0, hresp, "bus response");
    ahb(0, `SRCS_OFF_CAUSE, 0);
    chk(0, rd, "cause cleared");
    ahb(0, 32'h10, 0);
    chk(0, rd, "unmapped read");
    cnt(40);
    chk(10, b, "bus divide");
    repeat ($urandom_range(3000)) @(posedge clk);
    cpu_addr <= `SRCS_SERVICE_ADDR;
    cpu_write <= 1'h1;
    @(posedge clk);
    cpu_write <= 1'h0;
    ahb(0, `SRCS_OFF_STATUS, 0);
    chk(0, rd[11:0], "watchdog service");
    wait_exec <= 1'h1;
    @(posedge clk);
    wait_exec <= 1'h0;
    cnt(20);
    chk(0, c, "wait cpu clock");
    chk(5, b, "wait bus clock");
    wake_irq <= 1'h1;
    @(posedge clk);
    wake_irq <= 1'h0;
    $display("test clocks done");
    r = 8'($urandom_range(255, 1));
    i_mask <= 1'h1;
    irq_req <= r;
    repeat (3) @(posedge clk);
    chk(1, irq_pending, "irq latched");
    irq_req <= 8'hff;
    repeat (3) @(posedge clk);
    chk(lowest(r), irq_vector, "irq held");
    irq_req <= 8'h00;
    svc_delay <= 4'($urandom_range(15));
    svc_en <= 1'h1;
    repeat (20) @(posedge clk);
    chk(0, irq_pending, "irq serviced");
    svc_en <= 1'h0;
    irq_req <= r;
    repeat (3) @(posedge clk);
    chk(1, irq_pending, "irq relatched");
    i_mask <= 1'h0;
    repeat (2) @(posedge clk);
    chk(0, irq_pending, "irq unmasked");
    irq_req <= 8'h00;
    $display("test interrupts done");
    for (int s = 0; s < 2; s++) begin
      ahb(1, `SRCS_OFF_CONFIG, s ? 32'h1 : 32'h3);
      stop_exec <= 1'h1;
      @(posedge clk);
      stop_exec <= 1'h0;
      cnt(20);
      chk(0, b, "stop clocks");
      wake_irq <= 1'h1;
      @(posedge clk);
      wake_irq <= 1'h0;
      cnt(s ? 4088 : 28);
      chk(0, b, "stop delay");
      cnt(200);
      chk(1, b > 40, "stop wake");
    end
    $display("test stop done");
    unmapped_access <= 1'h1;
    @(posedge clk);
    unmapped_access <= 1'h0;
    repeat (4) @(posedge clk);
    chk(0, internal_reset, "data access");
    {monitor_mode, test_high_voltage, wdog_reset_in} <= 3'h7;
    repeat (4) @(posedge clk);
    chk(`SRCS_VEC_MON, reset_vector, "monitor vector");
    wdog_reset_in <= 1'h0;
    repeat (4) @(posedge clk);
    chk(0, internal_reset, "watchdog masked");
    {monitor_mode, test_high_voltage} <= 2'h0;
    @(posedge clk);
    chk(`SRCS_VEC_USER, reset_vector, "user vector");
    for (int k = 0; k < 6; k++) begin
      if (k == 5) ahb(1, `SRCS_OFF_CONFIG, 0);
      case (k)
        0: illegal_op <= 1'h1;
        1: {opcode_fetch, unmapped_access} <= 2'h3;
        2: wdog_reset_in <= 1'h1;
        3: lv_trip <= 1'h1;
        4: {vector_fetch, vector_data} <= {1'h1, `SRCS_ERASED};
        default: stop_exec <= 1'h1;
      endcase
      repeat (k == 3 ? $urandom_range(64, 1) : k == 2 ? 4 : 1) @(posedge clk);
      {illegal_op, opcode_fetch, unmapped_access, wdog_reset_in} <= '0;
      {lv_trip, vector_fetch, stop_exec} <= '0;
      repeat (4) @(posedge clk);
      run_wait();
      chk(1, n >= 4150 && n <= 4160, "source release");
      ahb(0, `SRCS_OFF_CAUSE, 0);
      chk(exp_cause[k], rd, "cause flag");
    end
    ahb(0, `SRCS_OFF_CONFIG, 0);
    chk(`SRCS_CFG_RESET, rd, "config default");
    chk(1, force_monitor, "monitor forced");
    chk(`SRCS_VEC_MON, reset_vector, "reset vector");
    $display("test reset sources done");
    final_report();
  end
endmodule
bind srcs_sequencer srcs_seq_asserts srcs_seq_asserts_i (.clk, .resetn,
  .bus_clk_en, .cpu_clk_en, .periph_clk_en, .cpu_reset, .internal_reset,
  .illegal_op, .opcode_fetch, .unmapped_access, .wdog_reset_in,
  .monitor_mode, .test_high_voltage, .force_monitor, .reset_vector, .i_mask,
  .irq_serviced, .irq_pending, .irq_vector);

// >>> inc/srcs_consts.svh
/*
  timing counts, register offsets and field positions of the reset and
  clock sequencer. assumes a 40 mhz clk that stands for the reference clock.
*/
`ifndef SRCS_CONSTS_SVH
`define SRCS_CONSTS_SVH
`define SRCS_BUS_DIV 3'd4
`define SRCS_STAB_CYCLES 13'd4096
`define SRCS_FETCH_CYCLES 13'd64
`define SRCS_SHORT_STOP_CYCLES 13'd32
`define SRCS_LONG_STOP_CYCLES 13'd4096
`define SRCS_WDOG_TOP 8'hff
`define SRCS_VEC_USER 16'hfffe
`define SRCS_VEC_MON 16'hfefe
`define SRCS_SERVICE_ADDR 16'hffff
`define SRCS_ERASED 8'hff
`define SRCS_OFF_CAUSE 32'h0000_0000
`define SRCS_OFF_CONFIG 32'h0000_0004
`define SRCS_OFF_STATUS 32'h0000_0008
`define SRCS_OFF_SERVICE 32'h0000_000c
`define SRCS_CFG_STOP_EN 0
`define SRCS_CFG_SHORT_REC 1
`define SRCS_CFG_LV_PWRD 2
`define SRCS_CFG_LV_RSTD 3
`define SRCS_CFG_RESET 4'h1
`define SRCS_NIRQ 8
`endif

// >>> inc/srcs_pkg.sv
/*
  types of the reset and clock sequencer.
  assumes srcs_consts.svh is on the include path.
*/
package srcs_pkg;
  typedef enum logic [2:0] {
    SEQ_STAB = 3'b000,
    SEQ_FETCH = 3'b001,
    SEQ_RUN = 3'b010,
    SEQ_STOP = 3'b011,
    SEQ_STOPREC = 3'b100,
    SEQ_LVHOLD = 3'b101
  } srcs_seq_e;
  typedef struct packed {
    logic low_voltage_detect;
    logic erased_vector_monitor_reset;
    logic illegal_address_flag;
    logic illegal_opcode_flag;
    logic wdog;
    logic por;
  } srcs_cause_s;
endpackage

// >>> rtl/srcs_sequencer.sv
/*
  reset and clock sequencer: bus clock enables, reset sources and release,
  cause register, watchdog, stop recovery, interrupt latch and arbiter.
  assumes one ahb-lite master, cpu status strobes synchronous to clk, and a
  power-on reset on resetn.
*/
// Operation
// RULE1: bus clock enable pulses every fourth reference cycle in user mode.
// RULE2: after power-on or low voltage, hold clocks and reset 4096 cycles.
// RULE3: wait 64 more cycles, then release cpu and memories from reset.
// RULE4: on stop exit, count reference cycles, clocks off until delay ends.
// RULE5: wait mode stops cpu clock; peripherals follow their own settings. Here periph_clk_en always equals bus_clk_en.
// RULE6: any internal reset asserts reset, vector fffe or fefe in monitor.
// RULE7: internal reset returns every register and module to default.
// RULE8: each internal reset clears the counter and sets its cause flag.
// RULE9: watchdog reset input is accepted asynchronously to the bus clock.
// RULE10: power-on asserts reset, enables clock output, sets only power flag.
// RULE11: watchdog overflow resets the chip and sets the watchdog flag.
// RULE12: any write to ffff clears watchdog and counter stages 12 to 5.
// RULE13: 12-bit counter on falling reference edge; overflow clocks watchdog. Here it counts on the rising clk edge.
// RULE14: watchdog disabled only by test voltage on irq pin in monitor mode.
// RULE15: illegal instruction sets illegal opcode flag and resets the chip.
// RULE16: stop with stop enable 0 is an illegal opcode reset.
// RULE17: only opcode fetch from unmapped address resets, data access not.
// RULE18: erased reset vector fetch resets and forces monitor mode.
// RULE19: enabled low voltage sets flag, holds reset, then 4096 plus 64.
// RULE20: stop clears counter; wake waits 32 if short recovery, else 4096.
// RULE21: after any reset recovery the counter runs freely.
// RULE22: interrupts latched, fixed priority; kept until serviced or unmasked.
// RULE23: reading the cause register clears its flags.
`timescale 1ns/1ps
`include "srcs_consts.svh"
module srcs_sequencer (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic wdog_reset_in,
  input wire logic lv_trip,
  input wire logic illegal_op,
  input wire logic stop_exec,
  input wire logic wait_exec,
  input wire logic opcode_fetch,
  input wire logic unmapped_access,
  input wire logic vector_fetch,
  input wire logic [7:0] vector_data,
  input wire logic cpu_write,
  input wire logic [15:0] cpu_addr,
  input wire logic monitor_mode,
  input wire logic test_high_voltage,
  input wire logic wake_irq,
  input wire logic [`SRCS_NIRQ-1:0] irq_req,
  input wire logic i_mask,
  input wire logic irq_serviced,
  output logic internal_reset,
  output logic cpu_reset,
  output logic clockgen_output,
  output logic bus_clk_en,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic [15:0] reset_vector,
  output logic force_monitor,
  output logic irq_pending,
  output logic [2:0] irq_vector
);
  srcs_pkg::srcs_seq_e seq;
  srcs_pkg::srcs_cause_s cause;
  logic [11:0] seq_cnt;
  logic [12:0] phase_cnt;
  logic [12:0] stop_len;
  logic [1:0] div_cnt;
  logic [3:0] cfg;
  logic [7:0] wdog_cnt;
  logic wdog_s1;
  logic wdog_s2;
  logic waiting;
  logic ph_valid;
  logic ph_write;
  logic [31:0] ph_addr;
  logic src_wdog;
  logic src_opcode;
  logic src_fetch;
  logic src_men;
  logic src_lowv;
  logic any_src;
  logic wdog_disable;
  logic service;
  logic cnt_ovf;
  logic cause_read;
  logic irq_latched;
  logic [2:0] next_irq;
  logic [11:0] next_cnt;

  // the counter advances on the falling edge in silicon; here it counts
  // once per clk, which is the same count of reference cycles
  assign cnt_ovf = (seq_cnt == 12'hfff);

  // the watchdog can be masked only by this gate, never by a register
  assign wdog_disable = monitor_mode & test_high_voltage; // RULE14

  // second synchroniser flop is the only reader of the first
  always_ff @(posedge clk or negedge resetn) begin // RULE9
    if (!resetn) begin
      wdog_s1 <= 1'b0;
      wdog_s2 <= 1'b0;
    end else begin
      wdog_s1 <= wdog_reset_in;
      wdog_s2 <= wdog_s1;
    end
  end

  assign src_wdog = !wdog_disable &&
    (wdog_s2 || (cnt_ovf && wdog_cnt == `SRCS_WDOG_TOP)); // RULE11
  assign src_opcode = illegal_op ||
    (stop_exec && !cfg[`SRCS_CFG_STOP_EN]); // RULE15 RULE16
  assign src_fetch = opcode_fetch && unmapped_access; // RULE17
  assign src_men = vector_fetch && vector_data == `SRCS_ERASED; // RULE18
  assign src_lowv = lv_trip && !cfg[`SRCS_CFG_LV_PWRD] &&
    !cfg[`SRCS_CFG_LV_RSTD]; // RULE19
  assign any_src = src_wdog | src_opcode | src_fetch | src_men | src_lowv;

  assign service = cpu_write && cpu_addr == `SRCS_SERVICE_ADDR; // RULE12

  // ahb-lite slave, zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= 32'h0000_0000;
    end else if (hready) begin
      ph_valid <= hsel && htrans[1] && hsize == 3'h2;
      ph_write <= hwrite;
      ph_addr <= haddr;
    end
  end

  assign cause_read = hsel && htrans[1] && !hwrite && hready &&
    haddr == `SRCS_OFF_CAUSE;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hsel && htrans[1] && !hwrite && hready) begin
      case (haddr)
        `SRCS_OFF_CAUSE: hrdata <= {26'h0, cause};
        `SRCS_OFF_CONFIG: hrdata <= {28'h0, cfg};
        `SRCS_OFF_STATUS: hrdata <= {17'h0, seq, wdog_cnt, seq_cnt[11:8]};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // config goes back to its default under every internal reset, so a
  // write that lands while the chip is held in reset is lost; software
  // must set it again once the cpu runs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg <= `SRCS_CFG_RESET;
    end else if (internal_reset) begin
      cfg <= `SRCS_CFG_RESET; // RULE7
    end else if (ph_valid && ph_write && ph_addr == `SRCS_OFF_CONFIG) begin
      cfg <= hwdata[3:0];
    end
  end

  // a source event wins over a clearing read in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cause <= 6'b000001; // RULE10
    end else if (any_src) begin // RULE8
      cause <= {src_lowv, src_men, src_fetch, src_opcode, src_wdog, 1'b0};
    end else if (cause_read) begin
      cause <= 6'b000000; // RULE23
    end
  end

  // sequencer and phase timer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      seq <= srcs_pkg::SEQ_STAB;
      phase_cnt <= 13'h0;
      stop_len <= `SRCS_LONG_STOP_CYCLES;
    end else if (src_lowv) begin
      seq <= srcs_pkg::SEQ_LVHOLD; // RULE19
      phase_cnt <= 13'h0;
    end else if (any_src && seq != srcs_pkg::SEQ_STOP) begin
      seq <= srcs_pkg::SEQ_STAB; // RULE6
      phase_cnt <= 13'h0;
    end else begin
      case (seq)
        srcs_pkg::SEQ_LVHOLD: begin
          seq <= srcs_pkg::SEQ_STAB;
          phase_cnt <= 13'h0;
        end
        srcs_pkg::SEQ_STAB: begin // RULE2
          if (phase_cnt == `SRCS_STAB_CYCLES - 13'd1) begin
            seq <= srcs_pkg::SEQ_FETCH;
            phase_cnt <= 13'h0;
          end else begin
            phase_cnt <= phase_cnt + 13'd1;
          end
        end
        srcs_pkg::SEQ_FETCH: begin // RULE3
          if (phase_cnt == `SRCS_FETCH_CYCLES - 13'd1) begin
            seq <= srcs_pkg::SEQ_RUN;
            phase_cnt <= 13'h0;
          end else begin
            phase_cnt <= phase_cnt + 13'd1;
          end
        end
        srcs_pkg::SEQ_RUN: begin
          if (stop_exec) begin
            seq <= srcs_pkg::SEQ_STOP;
          end
        end
        srcs_pkg::SEQ_STOP: begin // RULE20
          phase_cnt <= 13'h0;
          if (any_src) begin
            seq <= srcs_pkg::SEQ_STOPREC;
            stop_len <= `SRCS_LONG_STOP_CYCLES;
          end else if (wake_irq) begin
            seq <= srcs_pkg::SEQ_STOPREC;
            stop_len <= cfg[`SRCS_CFG_SHORT_REC] ? `SRCS_SHORT_STOP_CYCLES :
              `SRCS_LONG_STOP_CYCLES;
          end
        end
        srcs_pkg::SEQ_STOPREC: begin // RULE4
          if (phase_cnt == stop_len - 13'd1) begin
            seq <= (cause != 6'h0 && stop_len == `SRCS_LONG_STOP_CYCLES &&
              !wake_irq) ? srcs_pkg::SEQ_FETCH : srcs_pkg::SEQ_RUN;
            phase_cnt <= 13'h0;
          end else begin
            phase_cnt <= phase_cnt + 13'd1;
          end
        end
        default: seq <= srcs_pkg::SEQ_STAB;
      endcase
    end
  end

  // free-running counter, cleared in stop, partly cleared by service
  always_comb begin
    next_cnt = seq_cnt + 12'h001; // RULE21
    if (any_src || seq == srcs_pkg::SEQ_STOP || stop_exec) begin
      next_cnt = 12'h000; // RULE8 RULE20
    end else if (service) begin
      next_cnt = {8'h00, seq_cnt[3:0]}; // RULE12
    end
  end

  always_ff @(posedge clk or negedge resetn) begin // RULE13
    if (!resetn) begin
      seq_cnt <= 12'h000;
    end else begin
      seq_cnt <= next_cnt;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wdog_cnt <= 8'h00;
    end else if (any_src || service) begin
      wdog_cnt <= 8'h00; // RULE12
    end else if (cnt_ovf && seq == srcs_pkg::SEQ_RUN) begin
      wdog_cnt <= wdog_cnt + 8'h01; // RULE13
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt <= 2'h0;
    end else if (seq != srcs_pkg::SEQ_RUN) begin
      div_cnt <= 2'h0;
    end else begin
      div_cnt <= div_cnt + 2'h1; // RULE1
    end
  end

  // wait ends only on a latched interrupt or a reset source
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      waiting <= 1'b0;
    end else if (any_src || irq_pending) begin
      waiting <= 1'b0;
    end else if (wait_exec) begin
      waiting <= 1'b1;
    end
  end

  // erased-vector reset sticks into monitor mode until power-on
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      force_monitor <= 1'b0;
    end else if (src_men) begin
      force_monitor <= 1'b1; // RULE18
    end
  end

  assign bus_clk_en = seq == srcs_pkg::SEQ_RUN &&
    {1'b0, div_cnt} == `SRCS_BUS_DIV - 3'd1; // RULE1
  assign cpu_clk_en = bus_clk_en && !waiting; // RULE5
  assign periph_clk_en = bus_clk_en; // RULE5
  assign clockgen_output = seq != srcs_pkg::SEQ_STOP; // RULE10
  assign internal_reset = seq == srcs_pkg::SEQ_STAB ||
    seq == srcs_pkg::SEQ_LVHOLD; // RULE7
  assign cpu_reset = internal_reset || seq == srcs_pkg::SEQ_FETCH; // RULE3
  assign reset_vector = (monitor_mode || force_monitor) ?
    `SRCS_VEC_MON : `SRCS_VEC_USER; // RULE6

  // fixed priority, lowest index first; latched choice kept
  always_comb begin
    next_irq = 3'h0;
    for (int i = `SRCS_NIRQ - 1; i >= 0; i--) begin
      if (irq_req[i]) begin
        next_irq = i[2:0];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin // RULE22
    if (!resetn) begin
      irq_latched <= 1'b0;
      irq_vector <= 3'h0;
    end else if (internal_reset || irq_serviced || !i_mask) begin
      irq_latched <= 1'b0;
    end else if (!irq_latched && irq_req != 8'h00 && i_mask) begin
      irq_latched <= 1'b1;
      irq_vector <= next_irq;
    end
  end

  assign irq_pending = irq_latched;
endmodule
